// ===== core/dtm_timer.sv
// Contract
// - Control and data registers at fixed indices
// - Flag bit 7: write 0 clears, 1 keeps
// - Read-modify-write reads flag as one
// - Bit 6 enables the timer interrupt
// - Wave field: port, latch low, high, drive
// - Initial level reaches pin only when stopped
// - Timer A clock: 2, 32, 512, external
// - Timer B code 11 joins 16-bit mode
// - Bit 1 suspends counting, keeps count
// - Bit 0 start clears counter, then counts
// - Two 8-bit or one 16-bit, four clocks
// - Match sets flag, clears, reloads, continues
// - Data write sets interval, read gives count
// - 16-bit: A control, B high, A low byte
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module dtm_timer (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clk_en,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [dtm_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [dtm_pkg::DATA_W-1:0]  pwdata,
    input  wire logic                        rmw_access,
    output logic      [dtm_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        external_count_clock_pin,
    output logic                             square_wave_pin,
    output logic                             square_wave_oe,
    output logic                             irq
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [6:0]                  ctl_a;
        logic [6:0]                  ctl_b;
        logic                        flag_a;
        logic                        flag_b;
        logic [7:0]                  dat_a;
        logic [7:0]                  dat_b;
        logic [7:0]                  cnt_a;
        logic [7:0]                  cnt_b;
        logic [7:0]                  cmp_a;
        logic [7:0]                  cmp_b;
        logic [1:0]                  mask;
        logic                        level;
        logic                        wave;
        logic                        wave_oe;
        logic                        irq;
        logic                        xc_s1;
        logic                        xc_s2;
        logic                        xc_s3;
        dtm_pkg::dtm_apb_t           ph;
        logic [dtm_pkg::DATA_W-1:0]  rdata;
        logic                        slverr;
    } dtm_state_t;

    localparam dtm_state_t ST_RST = '{
        ctl_a   : dtm_pkg::CTL_RST,
        ctl_b   : dtm_pkg::CTL_RST,
        dat_a   : dtm_pkg::DAT_RST,
        dat_b   : dtm_pkg::DAT_RST,
        mask    : dtm_pkg::MASK_RST,
        ph      : dtm_pkg::APB_WAIT,
        default : '0
    };

    dtm_state_t r;
    dtm_state_t n;
    logic [2:0] pre_tick;

    // ****************************************
    // Helpers
    // ****************************************
    // Selects the count enable for a clock-select code
    function automatic logic tick_sel(
        input logic [1:0] cs,
        input logic [2:0] pt,
        input logic       ext
    );
        logic t;
        t = 1'b0;
        case (cs)
            dtm_pkg::CS_DIV2:   t = pt[0];
            dtm_pkg::CS_DIV32:  t = pt[1];
            dtm_pkg::CS_DIV512: t = pt[2];
            default:            t = ext;
        endcase
        return t;
    endfunction

    // One count step of an 8-bit channel: {match, next count}
    function automatic logic [8:0] step8(
        input logic [7:0] cnt,
        input logic [7:0] cmp
    );
        logic m;
        m = (cnt == cmp);
        return {m, m ? 8'h00 : cnt + 8'h01};
    endfunction

    function automatic logic [1:0] cs_of(input logic [6:0] c);
        return c[dtm_pkg::BIT_CS_HI:dtm_pkg::BIT_CS_LO];
    endfunction

    function automatic logic [1:0] wave_of(input logic [6:0] c);
        return c[dtm_pkg::BIT_WAVE_HI:dtm_pkg::BIT_WAVE_LO];
    endfunction

    // Start bit going from 0 to 1 in a control write
    function automatic logic start_edge(
        input logic [6:0] old_ctl,
        input logic [7:0] wr
    );
        return wr[dtm_pkg::BIT_START] & ~old_ctl[dtm_pkg::BIT_START];
    endfunction

    // Control readback; the flag reads as one in a read-modify-write
    function automatic logic [dtm_pkg::DATA_W-1:0] ctl_read(
        input logic       flag,
        input logic       rmw,
        input logic [6:0] ctl
    );
        return dtm_pkg::DATA_W'({flag | rmw, ctl});
    endfunction

    // ****************************************
    // Prescaler
    // ****************************************
    dtm_prescaler u_pre (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .tick    (pre_tick)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    logic        mode16;
    logic        ext_rise;
    logic        run_a;
    logic        run_b;
    logic        tick_a;
    logic        tick_b;
    logic        match_a;
    logic        match_b;
    logic        clr_a;
    logic        clr_b;
    logic        hit;
    logic [8:0]  sa;
    logic [8:0]  sb;
    logic [15:0] c16;
    logic [7:0]  idx;

    always_comb begin
        n        = r;
        match_a  = 1'b0;
        match_b  = 1'b0;
        clr_a    = 1'b0;
        clr_b    = 1'b0;
        sa       = 9'h000;
        sb       = 9'h000;
        c16      = 16'h0000;
        idx      = paddr[9:2];
        hit      = 1'b0;

        // External clock pin passes two flops before edge detection
        n.xc_s1  = external_count_clock_pin;
        n.xc_s2  = r.xc_s1;
        n.xc_s3  = r.xc_s2;
        ext_rise = r.xc_s2 & ~r.xc_s3;

        // Timer B code 11 pairs the channels; A alone relies on software
        mode16   = (cs_of(r.ctl_b) == dtm_pkg::CS_EXT);

        run_a    = r.ctl_a[dtm_pkg::BIT_START] & ~r.ctl_a[dtm_pkg::BIT_SUSP];
        run_b    = r.ctl_b[dtm_pkg::BIT_START] & ~r.ctl_b[dtm_pkg::BIT_SUSP];
        tick_a   = tick_sel(cs_of(r.ctl_a), pre_tick, ext_rise);
        tick_b   = tick_sel(cs_of(r.ctl_b), pre_tick, 1'b0);

        // ****************************************
        // Counting
        // ****************************************
        if (run_a && tick_a) begin
            if (mode16) begin
                // Paired counter uses B as the upper byte
                match_a = ({r.cnt_b, r.cnt_a} == {r.cmp_b, r.cmp_a});
                c16     = match_a ? 16'h0000 : {r.cnt_b, r.cnt_a} + 16'h0001;
                {n.cnt_b, n.cnt_a} = c16;
                if (match_a) begin
                    n.cmp_a = r.dat_a;
                    n.cmp_b = r.dat_b;
                end
            end else begin
                sa      = step8(r.cnt_a, r.cmp_a);
                match_a = sa[8];
                n.cnt_a = sa[7:0];
                if (match_a) begin
                    n.cmp_a = r.dat_a;
                end
            end
        end

        if (!mode16 && run_b && tick_b) begin
            sb      = step8(r.cnt_b, r.cmp_b);
            match_b = sb[8];
            n.cnt_b = sb[7:0];
            if (match_b) begin
                n.cmp_b = r.dat_b;
            end
        end

        // Toggle only while running with the wave function on
        if (match_a && wave_of(r.ctl_a) != dtm_pkg::WV_PORT) begin
            n.wave = ~r.wave;
        end

        // ****************************************
        // APB slave, one wait state per access
        // ****************************************
        hit = (paddr == dtm_pkg::byte_addr(dtm_pkg::IDX_TB_CTL))
            | (paddr == dtm_pkg::byte_addr(dtm_pkg::IDX_TA_CTL))
            | (paddr == dtm_pkg::byte_addr(dtm_pkg::IDX_TB_DAT))
            | (paddr == dtm_pkg::byte_addr(dtm_pkg::IDX_TA_DAT))
            | (paddr == dtm_pkg::byte_addr(dtm_pkg::IDX_IRQ_STAT))
            | (paddr == dtm_pkg::byte_addr(dtm_pkg::IDX_IRQ_MASK));

        if (psel && penable && r.ph == dtm_pkg::APB_WAIT) begin
            n.ph     = dtm_pkg::APB_ACK;
            n.slverr = ~hit;
            n.rdata  = '0;
            if (!pwrite && hit) begin
                case (idx)
                    dtm_pkg::IDX_TA_CTL:
                        n.rdata = ctl_read(r.flag_a, rmw_access, r.ctl_a);
                    dtm_pkg::IDX_TB_CTL:
                        n.rdata = ctl_read(r.flag_b, rmw_access, r.ctl_b);
                    dtm_pkg::IDX_TA_DAT:
                        n.rdata = 32'(r.cnt_a);
                    dtm_pkg::IDX_TB_DAT:
                        n.rdata = 32'(r.cnt_b);
                    dtm_pkg::IDX_IRQ_STAT:
                        n.rdata = 32'({r.flag_b, r.flag_a});
                    dtm_pkg::IDX_IRQ_MASK:
                        n.rdata = 32'(r.mask);
                    default:
                        n.rdata = '0;
                endcase
            end
        end else if (psel && penable && r.ph == dtm_pkg::APB_ACK) begin
            n.ph     = dtm_pkg::APB_WAIT;
            n.slverr = 1'b0;
            // Writes land at the edge where the master samples pready high
            if (pwrite && hit) begin
                case (idx)
                    dtm_pkg::IDX_TA_CTL: begin
                        clr_a   = ~pwdata[dtm_pkg::BIT_FLAG];
                        n.ctl_a = pwdata[6:0];
                        if (start_edge(r.ctl_a, pwdata[7:0])) begin
                            n.cnt_a = 8'h00;
                            n.cmp_a = r.dat_a;
                            if (mode16) begin
                                n.cnt_b = 8'h00;
                                n.cmp_b = r.dat_b;
                            end
                        end
                        case (pwdata[dtm_pkg::BIT_WAVE_HI:dtm_pkg::BIT_WAVE_LO])
                            dtm_pkg::WV_INIT_LO: n.level = 1'b0;
                            dtm_pkg::WV_INIT_HI: n.level = 1'b1;
                            dtm_pkg::WV_DRIVE: begin
                                if (!pwdata[dtm_pkg::BIT_START]) begin
                                    n.wave = r.level;
                                end
                            end
                            default: n.level = r.level;
                        endcase
                    end
                    dtm_pkg::IDX_TB_CTL: begin
                        clr_b   = ~pwdata[dtm_pkg::BIT_FLAG];
                        // Wave bits are stored only; software keeps them zero
                        n.ctl_b = pwdata[6:0];
                        if (start_edge(r.ctl_b, pwdata[7:0])) begin
                            n.cnt_b = 8'h00;
                            n.cmp_b = r.dat_b;
                        end
                    end
                    dtm_pkg::IDX_TA_DAT:
                        n.dat_a = pwdata[7:0];
                    dtm_pkg::IDX_TB_DAT:
                        n.dat_b = pwdata[7:0];
                    dtm_pkg::IDX_IRQ_STAT: begin
                        clr_a = pwdata[dtm_pkg::BIT_IRQ_A];
                        clr_b = pwdata[dtm_pkg::BIT_IRQ_B];
                    end
                    dtm_pkg::IDX_IRQ_MASK:
                        n.mask = pwdata[1:0];
                    default:
                        n.mask = r.mask;
                endcase
            end
        end

        // ****************************************
        // Flags and interrupt
        // ****************************************
        // A match in the clearing cycle is kept
        n.flag_a  = match_a | (r.flag_a & ~clr_a);
        n.flag_b  = match_b | (r.flag_b & ~clr_b);
        n.wave_oe = (wave_of(n.ctl_a) != dtm_pkg::WV_PORT);
        n.irq     = |({n.flag_b & n.ctl_b[dtm_pkg::BIT_IE],
                       n.flag_a & n.ctl_a[dtm_pkg::BIT_IE]} & n.mask);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= ST_RST;
        end else if (clk_en) begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata          = r.rdata;
    assign pready          = (r.ph == dtm_pkg::APB_ACK);
    assign pslverr         = r.slverr;
    assign square_wave_pin = r.wave;
    assign square_wave_oe  = r.wave_oe;
    assign irq             = r.irq;

endmodule

`default_nettype wire

// ===== core/dtm_pkg.sv
// ****************************************
// Dual interval timer constants
// ****************************************
`default_nettype none

package dtm_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ****************************************
    // Register indices, byte address is four times the index
    // ****************************************
    localparam logic [7:0] IDX_TB_CTL   = 8'h18;
    localparam logic [7:0] IDX_TA_CTL   = 8'h19;
    localparam logic [7:0] IDX_TB_DAT   = 8'h1a;
    localparam logic [7:0] IDX_TA_DAT   = 8'h1b;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h1c;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h1d;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int BIT_FLAG    = 7;
    localparam int BIT_IE      = 6;
    localparam int BIT_WAVE_HI = 5;
    localparam int BIT_WAVE_LO = 4;
    localparam int BIT_CS_HI   = 3;
    localparam int BIT_CS_LO   = 2;
    localparam int BIT_SUSP    = 1;
    localparam int BIT_START   = 0;

    // Interrupt status and mask share one layout
    localparam int BIT_IRQ_A = 0;
    localparam int BIT_IRQ_B = 1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [6:0] CTL_RST  = 7'h00;
    localparam logic [7:0] DAT_RST  = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h3;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [1:0] {
        CS_DIV2   = 2'h0,
        CS_DIV32  = 2'h1,
        CS_DIV512 = 2'h2,
        CS_EXT    = 2'h3
    } dtm_clksel_t;

    typedef enum logic [1:0] {
        WV_PORT    = 2'h0,
        WV_INIT_LO = 2'h1,
        WV_INIT_HI = 2'h2,
        WV_DRIVE   = 2'h3
    } dtm_wave_t;

    typedef enum logic {
        APB_WAIT = 1'h0,
        APB_ACK  = 1'h1
    } dtm_apb_t;

    // ****************************************
    // Timing: system clocks per instruction cycle and prescale ratios
    // ****************************************
    localparam int INSTR_CLKS = 4;
    localparam int INSTR_W    = $clog2(INSTR_CLKS);
    localparam int DIV_FAST   = 2;
    localparam int DIV_MID    = 32;
    localparam int DIV_SLOW   = 512;
    localparam int PRE_W      = $clog2(DIV_SLOW);

endpackage

`default_nettype wire

// ===== core/dtm_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Instruction-cycle prescaler, one-cycle ticks per rate
// ****************************************
module dtm_prescaler (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    output logic [2:0]      tick
);

    typedef struct packed {
        logic [dtm_pkg::INSTR_W-1:0] ic;
        logic [dtm_pkg::PRE_W-1:0]   pc;
        logic [2:0]                  tick;
    } dtm_pre_state_t;

    dtm_pre_state_t r;
    dtm_pre_state_t n;

    function automatic logic hit(input logic [dtm_pkg::PRE_W-1:0] pc, input int div);
        return (pc & dtm_pkg::PRE_W'(div - 1)) == dtm_pkg::PRE_W'(div - 1);
    endfunction

    always_comb begin
        n      = r;
        n.tick = 3'h0;
        if (r.ic == dtm_pkg::INSTR_W'(dtm_pkg::INSTR_CLKS - 1)) begin
            n.ic      = '0;
            n.pc      = r.pc + 1'b1;
            n.tick[0] = hit(r.pc, dtm_pkg::DIV_FAST);
            n.tick[1] = hit(r.pc, dtm_pkg::DIV_MID);
            n.tick[2] = hit(r.pc, dtm_pkg::DIV_SLOW);
        end else begin
            n.ic = r.ic + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
        end else if (clk_en) begin
            r <= n;
        end
    end

    assign tick = r.tick;

endmodule

`default_nettype wire

// ===== tb/dtm_timer_sva.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Port-level checks of the timer block
// ****************************************
module dtm_timer_sva (
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic                       clk_en,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [dtm_pkg::ADDR_W-1:0] paddr,
    input wire logic [dtm_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       square_wave_oe,
    input wire logic                       irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Mapped words sit at 0x060..0x074; anything else must error
    logic mapped;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr >= 12'h060) && (paddr <= 12'h074);

    AST_READY_NEEDS_REQ: assert property (pready |-> psel && penable)
        else $error("pready without an access phase");
    AST_WAIT_STATE: assert property ($rose(penable) && psel |-> !pready)
        else $error("no wait state in access phase");
    AST_READY_AFTER_WAIT: assert property (psel && penable && !pready && clk_en |=> pready)
        else $error("pready late");
    AST_READY_PULSE: assert property (pready && clk_en |=> !pready && !pslverr)
        else $error("pready longer than one cycle");
    AST_ERR_DECODE: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match decode");
    AST_UNMAPPED_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_OE_BY_WRITE: assert property ($changed(square_wave_oe) |->
        $past(pwrite && pready) || $past(pwrite && pready, 2))
        else $error("pin enable changed without a write");
    AST_IRQ_FALL_BY_WRITE: assert property ($fell(irq) |->
        $past(pwrite && pready) || $past(pwrite && pready, 2))
        else $error("irq fell without a write");
    AST_FREEZE: assert property (!clk_en |=> $stable(pready) && $stable(pslverr) && $stable(prdata)
        && $stable(irq) && $stable(square_wave_oe))
        else $error("outputs moved while clock enable low");
endmodule

bind dtm_timer dtm_timer_sva u_sva (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .square_wave_oe(square_wave_oe), .irq(irq)
);

`default_nettype wire

// ===== tb/dtm_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Software side: APB master for register access
// ****************************************
module dtm_cpu_model (
    input  wire logic                       clk,
    input  wire logic                       pready,
    input  wire logic [dtm_pkg::DATA_W-1:0] prdata,
    input  wire logic                       pslverr,
    output logic                            psel,
    output logic                            penable,
    output logic                            pwrite,
    output logic      [dtm_pkg::ADDR_W-1:0] paddr,
    output logic      [dtm_pkg::DATA_W-1:0] pwdata,
    output logic                            rmw_access
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        rmw_access = 1'b0;
    end

    // Entered just after a rising edge; an idle edge follows so no signal is set twice at once
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic rmw,
                        output logic [31:0] q, output logic e);
        logic [7:0] dd;
        dd = d;
        if (w && a == 12'h060) begin
            dd[5:4] = 2'h0;
        end
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, dd};
        rmw_access <= rmw;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        rmw_access <= 1'b0;
        @(posedge clk);
    endtask
endmodule

`default_nettype wire

// ===== tb/dtm_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none

module dtm_timer_tb;
    localparam logic [11:0] RBC = 12'h060;
    localparam logic [11:0] RAC = 12'h064;
    localparam logic [11:0] RBD = 12'h068;
    localparam logic [11:0] RAD = 12'h06c;
    localparam logic [11:0] RST = 12'h070;
    localparam logic [11:0] RMK = 12'h074;

    logic clk, sys_rst, cen, ext, ext_on, psel, penable, pwrite, rmw, pready, pslverr, pin, oe, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int err_total = 0;
    int check_count = 0;

    dtm_timer dut (.clk(clk), .sys_rst(sys_rst), .clk_en(cen), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rmw_access(rmw), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_count_clock_pin(ext), .square_wave_pin(pin),
        .square_wave_oe(oe), .irq(irq));
    dtm_cpu_model cpu (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rmw_access(rmw));

    // ****************************************
    // Clock, reset, external count clock
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // External clock of 8 system clocks, well above the two-clock minimum pulse
    always begin
        if (ext_on) begin
            ext <= 1'b1;
            repeat (4) @(posedge clk);
            ext <= 1'b0;
            repeat (4) @(posedge clk);
        end else begin
            ext <= 1'b0;
            @(posedge clk);
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        cpu.xfer(1'b1, a, d, 1'b0, q, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q, input logic m = 1'b0);
        logic e;
        cpu.xfer(1'b0, a, 8'h00, m, q, e);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] x, input logic m = 1'b0);
        logic [31:0] q;
        rd(a, q, m);
        chk(q, {24'h0, x});
    endtask
    // Clocks between the first and second level change of the wave pin
    task automatic meas(output int c);
        logic v;
        v = pin;
        @(posedge clk iff pin !== v);
        v = pin;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (pin === v);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rdc(RBC, 8'h00); rdc(RAC, 8'h00); rdc(RBD, 8'h00); rdc(RAD, 8'h00);
        rdc(RST, 8'h00); rdc(RMK, 8'h03);
        cpu.xfer(1'b1, 12'h078, 8'hff, 1'b0, q, e);
        chk({31'h0, e}, 32'h1);
        cpu.xfer(1'b0, 12'h078, 8'h00, 1'b0, q, e);
        chk({e, q[30:0]}, 32'h8000_0000);
    endtask

    task automatic t_wave();
        int c;
        int dv[4] = '{8, 128, 2048, 8};
        wr(RAD, 8'h02);
        wr(RAC, 8'h10);
        wr(RAC, 8'h30);
        chk({oe, pin}, 32'h2);
        wr(RAC, 8'h20);
        wr(RAC, 8'h30);
        chk({oe, pin}, 32'h3);
        wr(RAC, 8'h10);
        wr(RAC, 8'h31);
        chk({oe, pin}, 32'h3);
        wr(RAC, 8'h30);
        for (int cs = 0; cs < 4; cs++) begin
            ext_on = (cs == 3);
            wr(RAC, 8'h31 | 8'(cs << 2));
            meas(c);
            chk(c, 3 * dv[cs]);
            wr(RAC, 8'h30);
        end
        ext_on = 1'b0;
    endtask

    task automatic t_susp();
        logic [31:0] c1, c2, c3, c4, c5;
        wr(RAD, 8'hff);
        wr(RAC, 8'h01);
        repeat (100) @(posedge clk);
        wr(RAC, 8'h03);
        rd(RAD, c1);
        repeat (40) @(posedge clk);
        rd(RAD, c2);
        chk(c2, c1);
        wr(RAC, 8'h01);
        repeat (40) @(posedge clk);
        rd(RAD, c3);
        chk({31'h0, (c3 - c1) inside {[5:8]}}, 32'h1);
        cen <= 1'b0;
        repeat (40) @(posedge clk);
        cen <= 1'b1;
        rd(RAD, c5);
        chk({31'h0, (c5 - c3) < 2}, 32'h1);
        wr(RAC, 8'h00);
        wr(RAC, 8'h01);
        rd(RAD, c4);
        chk({31'h0, c4 < 2}, 32'h1);
        wr(RAC, 8'h00);
    endtask

    task automatic t_wide();
        int c;
        wr(RBC, 8'h0c);
        wr(RAD, 8'h02);
        wr(RBD, 8'h01);
        wr(RST, 8'h03);
        wr(RAC, 8'h31);
        meas(c);
        chk(c, 259 * 8);
        rdc(RST, 8'h01);
        wr(RAC, 8'h30);
        wr(RBC, 8'h00);
        wr(RST, 8'h03);
    endtask

    task automatic t_irq();
        wr(RBD, 8'h01);
        wr(RBC, 8'h41);
        repeat (40) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rdc(RST, 8'h02);
        wr(RMK, 8'h01);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(RMK, 8'h03);
        wr(RBC, 8'hc0);
        rdc(RBC, 8'hc0);
        chk({31'h0, irq}, 32'h1);
        wr(RBC, 8'h40);
        rdc(RBC, 8'h40);
        rdc(RBC, 8'hc0, 1'b1);
        chk({31'h0, irq}, 32'h0);
        wr(RBC, 8'h01);
        repeat (60) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(RBC, 8'h80);
        rdc(RST, 8'h02);
        wr(RST, 8'h02);
        rdc(RST, 8'h00);
    endtask

    // ****************************************
    // Sequence, watchdog and verdict
    // ****************************************
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        ext_on = 1'b0;
        cen = 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_wave();
        t_susp();
        t_wide();
        t_irq();
        tally_and_finish();
    end

    // Longest path is the slow prescale and the wide period, about 20k clocks
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
